/* rtl/tlic_pkg.sv */
// shared constants and types for the two-level interrupt controller
package tlic_pkg;
   localparam logic [7:0] TLIC_OFF_MAIN_CTL = 8'h00;
   localparam logic [7:0] TLIC_OFF_RESET_CTL = 8'h04;
   localparam logic [7:0] TLIC_OFF_SEL = 8'h08;
   localparam logic [7:0] TLIC_OFF_PFLAG = 8'h0C;
   localparam logic [7:0] TLIC_OFF_PEN = 8'h10;
   localparam logic [7:0] TLIC_OFF_PLVL = 8'h14;
   localparam logic [7:0] TLIC_OFF_STATUS = 8'h18;
   localparam logic [7:0] TLIC_OFF_PORT = 8'h1C;
   localparam int TLIC_BIT_PRIO_ON = 7;
   localparam int TLIC_BIT_EDGE_SEL = 6;
   localparam int TLIC_BIT_T0_LVL = 2;
   localparam int TLIC_BIT_RB_LVL = 0;
   localparam int TLIC_BIT_ST_LO = 0;
   localparam int TLIC_BIT_ST_HI = 1;
   localparam logic [7:0] TLIC_RST_MAIN_CTL = 8'h00;
   localparam logic [7:0] TLIC_RST_RESET_CTL = 8'h00;
   localparam logic [7:0] TLIC_RST_SEL = 8'h45;
   localparam logic [20:0] TLIC_VEC_HI = 21'h000008;
   localparam logic [20:0] TLIC_VEC_LO = 21'h000018;
   typedef struct packed {
      logic glb_hi_on;
      logic glb_lo_on;
      logic t0_en;
      logic int0_en;
      logic rb_en;
      logic t0_flag;
      logic int0_flag;
      logic rb_flag;
   } tlic_main_ctl_t;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } tlic_apb_req_t;
   typedef enum logic [3:0] {
      TLIC_ST_IDLE = 4'h1,
      TLIC_ST_LO = 4'h2,
      TLIC_ST_HI = 4'h4,
      TLIC_ST_HILO = 4'h8
   } tlic_state_t;
endpackage

/* rtl/tlic_top.sv */
// two-level prioritised interrupt controller with apb register access
// Functional notes
// - priority mode vectors high 0008h, low 0018h
// - high request preempts running low routine
// - each source has flag, enable, level; external line zero has no level
// - priority mode only when priority_scheme_on set
// - high_level/low_level enables gate by level
// - flag, enable, global all set: vector
// - level bits ignored in compatibility mode
// - compat: bit6 peripheral gate, bit7 global
// - compat: every interrupt vectors to 0008h
// - accept clears the governing global enable
// - no low service during high routine
// - accept pushes return address, loads vector
// - return restores pc and re-arms enable
// - pin interrupt latency three to four instructions
// - flags set regardless of any enable
// - bit7 enables high level; zero disables all
// - bit6 enables low level sources
// - main register enable and flag layout
// - port change flag follows upper nibble mismatch
// - two global enables, per-source masks remain
// - edge select one rising, zero falling
`timescale 1ns/1ps
module tlic_top
   import tlic_pkg::*;
#(
   parameter int NPER = 8,
   parameter int AW = 21
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_line_zero_pin,
   input wire logic [3:0] upper_port_nibble,
   input wire logic timer_zero_ovf,
   input wire logic [NPER-1:0] periph_event,
   input wire logic instr_boundary,
   input wire logic return_from_service,
   input wire logic [AW-1:0] return_addr,
   output logic pc_load,
   output logic [AW-1:0] pc_load_addr,
   output logic hi_in_service,
   output logic lo_in_service
);
   initial begin
      if (NPER < 1 || NPER > 24) begin
         $error("NPER must be 1 to 24");
      end
      if (AW < 8 || AW > 32) begin
         $error("AW must be 8 to 32");
      end
   end

   tlic_main_ctl_t main_ctl_reg;
   tlic_main_ctl_t main_ctl_next;
   logic [7:0] rctl_reg;
   logic [7:0] sel_reg;
   logic [NPER-1:0] pflag_reg;
   logic [NPER-1:0] pen_reg;
   logic [NPER-1:0] plvl_reg;
   tlic_state_t state_reg;
   tlic_state_t state_next;
   logic [AW-1:0] stack_reg [2];
   logic [2:0] ext_sync_reg;
   logic ext_lvl_reg;
   logic [2:0] port_sync_reg [4];
   logic [3:0] port_lvl_reg;
   logic [3:0] port_snap_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic pc_load_reg;
   logic [AW-1:0] pc_addr_reg;
   logic hi_srv_reg;
   logic lo_srv_reg;

   tlic_apb_req_t req;
   logic access;
   logic done;
   logic wr_done;
   logic rd_done;
   logic mapped;
   logic [31:0] rd_val;
   logic prio_on;
   logic ext_edge;
   logic [3:0] port_lvl_next;
   logic port_mismatch;
   logic [2:0] core_pend;
   logic [2:0] core_lvl;
   logic [2:0] core_periph;
   logic [NPER-1:0] per_pend;
   logic hi_req;
   logic lo_req;
   logic take_hi;
   logic take_lo;
   logic take;
   logic stack_pop_idx;

   assign req = '{addr: paddr[7:0], write: pwrite, wdata: pwdata};
   assign access = psel && penable;
   // one wait state keeps read data coming straight from a flop
   assign done = access && pready_reg;
   assign wr_done = done && req.write && mapped;
   assign rd_done = done && !req.write && mapped;
   assign mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00) && (paddr[7:0] <= TLIC_OFF_PORT);

   assign prio_on = rctl_reg[TLIC_BIT_PRIO_ON];

   always_comb begin
      rd_val = 32'h00000000;
      case (req.addr)
         TLIC_OFF_MAIN_CTL: rd_val[7:0] = main_ctl_reg;
         TLIC_OFF_RESET_CTL: rd_val[7:0] = rctl_reg;
         TLIC_OFF_SEL: rd_val[7:0] = sel_reg;
         TLIC_OFF_PFLAG: rd_val[NPER-1:0] = pflag_reg;
         TLIC_OFF_PEN: rd_val[NPER-1:0] = pen_reg;
         TLIC_OFF_PLVL: rd_val[NPER-1:0] = plvl_reg;
         TLIC_OFF_STATUS: begin
            rd_val[TLIC_BIT_ST_LO] = (state_reg == TLIC_ST_LO) || (state_reg == TLIC_ST_HILO);
            rd_val[TLIC_BIT_ST_HI] = (state_reg == TLIC_ST_HI) || (state_reg == TLIC_ST_HILO);
         end
         TLIC_OFF_PORT: rd_val[3:0] = port_lvl_reg;
         default: rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= access && !pready_reg;
         pslverr_reg <= access && !pready_reg && !mapped;
         if (access && !pready_reg) begin
            prdata_reg <= mapped && !req.write ? rd_val : 32'h00000000;
         end
      end
   end

   // pin input: three flops, a level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync_reg <= 3'h0;
         ext_lvl_reg <= 1'b0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_line_zero_pin};
         if (ext_sync_reg[1] == ext_sync_reg[2]) begin
            ext_lvl_reg <= ext_sync_reg[2];
         end
      end
   end

   assign ext_edge = (ext_sync_reg[1] == ext_sync_reg[2]) && (ext_sync_reg[2] != ext_lvl_reg) &&
      (ext_sync_reg[2] == sel_reg[TLIC_BIT_EDGE_SEL]);

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_port
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               port_sync_reg[gb] <= 3'h0;
            end else begin
               port_sync_reg[gb] <= {port_sync_reg[gb][1:0], upper_port_nibble[gb]};
            end
         end
         assign port_lvl_next[gb] = (port_sync_reg[gb][1] == port_sync_reg[gb][2]) ?
            port_sync_reg[gb][2] : port_lvl_reg[gb];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_lvl_reg <= 4'h0;
         port_snap_reg <= 4'h0;
      end else begin
         port_lvl_reg <= port_lvl_next;
         // reading the port ends the mismatch
         if (rd_done && req.addr == TLIC_OFF_PORT) begin
            port_snap_reg <= port_lvl_reg;
         end
      end
   end

   assign port_mismatch = port_lvl_reg != port_snap_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rctl_reg <= TLIC_RST_RESET_CTL;
         sel_reg <= TLIC_RST_SEL;
         pen_reg <= '0;
         plvl_reg <= '0;
      end else if (wr_done) begin
         case (req.addr)
            TLIC_OFF_RESET_CTL: rctl_reg <= req.wdata[7:0] & 8'h80;
            TLIC_OFF_SEL: sel_reg <= req.wdata[7:0];
            TLIC_OFF_PEN: pen_reg <= req.wdata[NPER-1:0];
            TLIC_OFF_PLVL: plvl_reg <= req.wdata[NPER-1:0];
            default: ;
         endcase
      end
   end

   // peripheral flags: an event on the same edge as a clear wins
   genvar gp;
   generate
      for (gp = 0; gp < NPER; gp++) begin : g_pflag
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pflag_reg[gp] <= 1'b0;
            end else if (periph_event[gp]) begin
               pflag_reg[gp] <= 1'b1;
            end else if (wr_done && req.addr == TLIC_OFF_PFLAG) begin
               pflag_reg[gp] <= req.wdata[gp];
            end
         end
         assign per_pend[gp] = pflag_reg[gp] && pen_reg[gp];
      end
   endgenerate

   // core sources: timer zero, external line zero, port change
   assign core_pend = {main_ctl_reg.t0_flag && main_ctl_reg.t0_en,
      main_ctl_reg.int0_flag && main_ctl_reg.int0_en,
      main_ctl_reg.rb_flag && main_ctl_reg.rb_en};
   // external line zero has no level select and always runs high
   assign core_lvl = {sel_reg[TLIC_BIT_T0_LVL], 1'b1, sel_reg[TLIC_BIT_RB_LVL]};
   assign core_periph = 3'b000;

   always_comb begin
      hi_req = 1'b0;
      lo_req = 1'b0;
      if (prio_on) begin
         // bit7 low stops everything, bit6 only the low level
         hi_req = main_ctl_reg.glb_hi_on && ((|(core_pend & core_lvl)) || (|(per_pend & plvl_reg)));
         lo_req = main_ctl_reg.glb_hi_on && main_ctl_reg.glb_lo_on &&
            ((|(core_pend & ~core_lvl)) || (|(per_pend & ~plvl_reg)));
         lo_req = lo_req && (state_reg == TLIC_ST_IDLE);
         hi_req = hi_req && (state_reg == TLIC_ST_IDLE || state_reg == TLIC_ST_LO);
      end else begin
         // level bits play no part here
         hi_req = main_ctl_reg.glb_hi_on && ((|(core_pend & ~core_periph)) ||
            (main_ctl_reg.glb_lo_on && (|per_pend)));
      end
   end

   // accept only at an instruction boundary, so a multi-cycle instruction can delay acceptance by a cycle
   assign take_hi = instr_boundary && !return_from_service && hi_req;
   assign take_lo = instr_boundary && !return_from_service && lo_req && !hi_req;
   assign take = take_hi || take_lo;

   always_comb begin
      main_ctl_next = main_ctl_reg;
      if (wr_done && req.addr == TLIC_OFF_MAIN_CTL) begin
         main_ctl_next = tlic_main_ctl_t'(req.wdata[7:0]);
      end
      if (return_from_service) begin
         if (state_reg == TLIC_ST_LO && prio_on) begin
            main_ctl_next.glb_lo_on = 1'b1;
         end else if (state_reg != TLIC_ST_IDLE) begin
            main_ctl_next.glb_hi_on = 1'b1;
         end
      end
      if (take_hi) begin
         main_ctl_next.glb_hi_on = 1'b0;
      end
      if (take_lo) begin
         main_ctl_next.glb_lo_on = 1'b0;
      end
      main_ctl_next.t0_flag = main_ctl_next.t0_flag || timer_zero_ovf;
      main_ctl_next.int0_flag = main_ctl_next.int0_flag || ext_edge;
      main_ctl_next.rb_flag = main_ctl_next.rb_flag || port_mismatch;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_ctl_reg <= tlic_main_ctl_t'(TLIC_RST_MAIN_CTL);
      end else begin
         main_ctl_reg <= main_ctl_next;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TLIC_ST_IDLE: begin
            if (take_hi) begin
               state_next = TLIC_ST_HI;
            end else if (take_lo) begin
               state_next = TLIC_ST_LO;
            end
         end
         TLIC_ST_LO: begin
            if (return_from_service) begin
               state_next = TLIC_ST_IDLE;
            end else if (take_hi) begin
               state_next = TLIC_ST_HILO;
            end
         end
         TLIC_ST_HI: begin
            if (return_from_service) begin
               state_next = TLIC_ST_IDLE;
            end
         end
         TLIC_ST_HILO: begin
            if (return_from_service) begin
               state_next = TLIC_ST_LO;
            end
         end
         default: state_next = TLIC_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= TLIC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // one return slot per level; nesting never goes deeper than low under high
   assign stack_pop_idx = (state_reg == TLIC_ST_HI) || (state_reg == TLIC_ST_HILO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_reg[0] <= '0;
         stack_reg[1] <= '0;
      end else if (take) begin
         stack_reg[take_hi] <= return_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load_reg <= 1'b0;
         pc_addr_reg <= '0;
      end else begin
         pc_load_reg <= take || (return_from_service && state_reg != TLIC_ST_IDLE);
         if (take_hi) begin
            pc_addr_reg <= AW'(TLIC_VEC_HI);
         end else if (take_lo) begin
            pc_addr_reg <= AW'(TLIC_VEC_LO);
         end else if (return_from_service && state_reg != TLIC_ST_IDLE) begin
            pc_addr_reg <= stack_reg[stack_pop_idx];
         end
      end
   end

   // service levels kept in their own flops so the core never sees decode glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_srv_reg <= 1'b0;
         lo_srv_reg <= 1'b0;
      end else begin
         hi_srv_reg <= (state_next == TLIC_ST_HI) || (state_next == TLIC_ST_HILO);
         lo_srv_reg <= (state_next == TLIC_ST_LO) || (state_next == TLIC_ST_HILO);
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pc_load = pc_load_reg;
   assign pc_load_addr = pc_addr_reg;
   assign hi_in_service = hi_srv_reg;
   assign lo_in_service = lo_srv_reg;
endmodule

/* dv/tlic_sva.sv */
// port checker for the interrupt controller
`timescale 1ns/1ps
module tlic_sva
   import tlic_pkg::*;
#(
   parameter int AW = 21
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instr_boundary,
   input wire logic return_from_service,
   input wire logic pc_load,
   input wire logic [AW-1:0] pc_load_addr,
   input wire logic hi_in_service,
   input wire logic lo_in_service
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_ret;
      return_from_service && (hi_in_service || lo_in_service);
   endsequence
   property p_ready_wait;
      s_setup |-> !pready ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("pslverr without pready or with data");
   property p_hi_vec;
      $rose(hi_in_service) |-> pc_load && pc_load_addr == TLIC_VEC_HI;
   endproperty
   a_hi_vec: assert property (p_hi_vec) else $error("high entry without high vector");
   property p_lo_vec;
      $rose(lo_in_service) |-> pc_load && pc_load_addr == TLIC_VEC_LO;
   endproperty
   a_lo_vec: assert property (p_lo_vec) else $error("low entry without low vector");
   property p_at_boundary;
      pc_load && !$past(return_from_service) |-> $past(instr_boundary);
   endproperty
   a_at_boundary: assert property (p_at_boundary) else $error("vector load off a boundary");
   property p_lo_blocked;
      hi_in_service && !lo_in_service |=> !$rose(lo_in_service);
   endproperty
   a_lo_blocked: assert property (p_lo_blocked) else $error("low taken during high routine");
   property p_ret_load;
      s_ret |=> pc_load;
   endproperty
   a_ret_load: assert property (p_ret_load) else $error("return gave no load");
   property p_preempt;
      $rose(hi_in_service) && lo_in_service |-> $past(lo_in_service) && !$past(hi_in_service);
   endproperty
   a_preempt: assert property (p_preempt) else $error("bad nesting of high over low");
endmodule
bind tlic_top tlic_sva #(.AW(AW)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
   .return_from_service(return_from_service), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
   .hi_in_service(hi_in_service), .lo_in_service(lo_in_service));

/* dv/tlic_core_model.sv */
// core model: instruction boundaries, returns and a return-address stack
`timescale 1ns/1ps
module tlic_core_model #(
   parameter int AW = 21
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic ret_go,
   input wire logic pc_load,
   input wire logic [AW-1:0] pc_load_addr,
   output logic instr_boundary,
   output logic return_from_service,
   output logic [AW-1:0] return_addr,
   output logic [AW-1:0] stack_top
);
   logic [AW-1:0] stk [0:3];
   logic [1:0] sp_reg;
   logic [AW-1:0] prev_ra_reg;
   logic pop_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_boundary <= 1'b0;
         return_from_service <= 1'b0;
         return_addr <= '0;
         prev_ra_reg <= '0;
         pop_reg <= 1'b0;
         sp_reg <= 2'h0;
      end else begin
         // slow mode leaves gaps, as two-cycle instructions do
         instr_boundary <= slow ? !instr_boundary : 1'b1;
         return_from_service <= ret_go;
         pop_reg <= return_from_service;
         prev_ra_reg <= return_addr;
         if (pc_load) begin
            if (pop_reg) begin
               sp_reg <= sp_reg - 2'h1;
            end else begin
               stk[sp_reg] <= prev_ra_reg;
               sp_reg <= sp_reg + 2'h1;
            end
            return_addr <= pc_load_addr;
         end else if (instr_boundary) begin
            return_addr <= return_addr + 1'b1;
         end
      end
   end
   assign stack_top = stk[sp_reg - 2'h1];
endmodule

/* dv/tb_top.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
   import tlic_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_pin, t0_ovf, slow, ret_go;
   logic ib, rfs, pc_load, hi, lo;
   logic [31:0] paddr, pwdata, prdata;
   logic [7:0] pev, pev_acc;
   logic [3:0] port_pins;
   logic [15:0] rnd;
   logic [20:0] ra, pla, stop;
   logic [32:0] ev;
   logic [32:0] exp_rd[$];
   logic [20:0] exp_pc[$];
   int n_fail, num_checks;
   tlic_top #(.NPER(8), .AW(21)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_line_zero_pin(ext_pin), .upper_port_nibble(port_pins), .timer_zero_ovf(t0_ovf), .periph_event(pev),
      .instr_boundary(ib), .return_from_service(rfs), .return_addr(ra), .pc_load(pc_load),
      .pc_load_addr(pla), .hi_in_service(hi), .lo_in_service(lo));
   tlic_core_model #(.AW(21)) u_core (.pclk(pclk), .presetn(presetn), .slow(slow), .ret_go(ret_go),
      .pc_load(pc_load), .pc_load_addr(pla), .instr_boundary(ib), .return_from_service(rfs),
      .return_addr(ra), .stack_top(stop));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // monitor: every answer takes the oldest note
   always @(posedge pclk) begin
      if (presetn === 1'b1 && pready === 1'b1) begin
         ev = (exp_rd.size() > 0) ? exp_rd.pop_front() : 33'h1FFFFFFFF;
         chk("apb", ev, {pslverr, pwrite ? ev[31:0] : prdata});
      end
      if (presetn === 1'b1 && pc_load === 1'b1) begin
         ev = (exp_pc.size() > 0) ? {12'h0, exp_pc.pop_front()} : 33'h1FFFFFFFF;
         chk("pc_load_addr", ev, {12'h0, pla});
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int i;
      exp_rd.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
      if (i == 20) begin
         n_fail++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, {25'h0, e});
   endtask
   task automatic drain;
      int i;
      for (i = 0; i < 40 && exp_pc.size() != 0; i++) @(posedge pclk);
      if (exp_pc.size() != 0) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic ret;
      exp_pc.push_back(stop);
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, ext_pin, t0_ovf, slow, ret_go} = 8'h00;
      {paddr, pwdata, pev, pev_acc} = 80'h0;
      rnd = 16'hD94B;
      port_pins = 4'h0;
      n_fail = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h00, 8'h00);
      rd(TLIC_OFF_RESET_CTL, TLIC_RST_RESET_CTL);
      rd(TLIC_OFF_SEL, TLIC_RST_SEL);
      rd(TLIC_OFF_STATUS, 8'h00);
      apb(1'b0, 8'h20, 32'h0, 33'h100000000);
      // flags latch random events although every gate is closed
      repeat (4) begin
         rnd = lfsr(rnd);
         pev <= rnd[7:0];
         pev_acc = pev_acc | rnd[7:0];
         @(posedge pclk);
      end
      pev <= 8'h00;
      repeat (2) @(posedge pclk);
      rd(TLIC_OFF_PFLAG, pev_acc);
      wr(TLIC_OFF_PFLAG, 32'h0);
      $display("test reset done");
      wr(TLIC_OFF_SEL, 32'h40);
      wr(8'h00, 32'hA0);
      exp_pc.push_back(TLIC_VEC_HI);
      t0_ovf <= 1'b1;
      @(posedge pclk);
      t0_ovf <= 1'b0;
      drain();
      rd(8'h00, 8'h24);
      rd(TLIC_OFF_STATUS, 8'h02);
      wr(8'h00, 32'h20);
      ret();
      drain();
      rd(8'h00, 8'hA0);
      wr(TLIC_OFF_PEN, 32'h1);
      pev <= 8'h01;
      @(posedge pclk);
      pev <= 8'h00;
      repeat (8) @(posedge pclk);
      exp_pc.push_back(TLIC_VEC_HI);
      wr(8'h00, 32'hE0);
      drain();
      wr(TLIC_OFF_PFLAG, 32'h0);
      wr(TLIC_OFF_PEN, 32'h0);
      ret();
      drain();
      $display("test compat done");
      // slow boundaries; gates shut before the mode changes
      slow <= 1'b1;
      wr(8'h00, 32'h00);
      wr(TLIC_OFF_RESET_CTL, 32'h80);
      exp_pc.push_back(TLIC_VEC_HI);
      wr(8'h00, 32'hF6);
      drain();
      repeat (10) @(posedge pclk);
      rd(8'h00, 8'h76);
      wr(8'h00, 32'h74);
      ret();
      exp_pc.push_back(TLIC_VEC_LO);
      drain();
      rd(8'h00, 8'hB4);
      rd(TLIC_OFF_STATUS, 8'h01);
      exp_pc.push_back(TLIC_VEC_HI);
      ext_pin <= 1'b1;
      drain();
      rd(TLIC_OFF_STATUS, 8'h03);
      rd(8'h00, 8'h36);
      wr(8'h00, 32'h34);
      ret();
      drain();
      wr(8'h00, 32'hB0);
      ret();
      drain();
      rd(8'h00, 8'hF0);
      wr(8'h00, 32'h00);
      wr(TLIC_OFF_SEL, 32'h00);
      ext_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(8'h00, 8'h02);
      // port change: flag re-sets until the port is read
      port_pins <= 4'h5;
      repeat (6) @(posedge pclk);
      wr(8'h00, 32'h00);
      rd(8'h00, 8'h01);
      rd(TLIC_OFF_PORT, 8'h05);
      wr(8'h00, 32'h00);
      rd(8'h00, 8'h00);
      $display("test priority done");
      print_verdict();
   end
endmodule
